// *** include/pmrf_pkg.sv ***
// Constants for the per-port transceiver management register file.
// Assumes a management host clocking frames far slower than clk_sys.
`default_nettype none
package pmrf_pkg;
    // Register addresses on the management frame
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_STATUS    = 5'h01;
    localparam logic [4:0]  REG_IDENT_HI  = 5'h02;
    localparam logic [4:0]  REG_IDENT_LO  = 5'h03;
    localparam logic [4:0]  REG_ADVERT    = 5'h04;
    // Control field positions
    localparam int CTRL_NEG_ON     = 12;
    localparam int CTRL_RENEG      = 9;
    localparam int CTRL_DUPLEX     = 8;
    localparam int CTRL_ALGO       = 5;
    localparam int CTRL_STRAIGHT   = 4;
    localparam int CTRL_AUTO_OFF   = 3;
    localparam int CTRL_FAULT_OFF  = 2;
    localparam int CTRL_TX_OFF     = 1;
    localparam int CTRL_IND_OFF    = 0;
    // Control reset values
    localparam logic CTRL_NEG_ON_RST    = 1'b1;
    localparam logic CTRL_DUPLEX_RST    = 1'b1;
    localparam logic CTRL_ALGO_RST      = 1'b1;
    // Status field positions and fixed content
    localparam int STAT_DONE       = 5;
    localparam int STAT_FAULT      = 4;
    localparam int STAT_LINK       = 2;
    localparam logic [15:0] STAT_FIXED = 16'h7808;
    // Advertisement fields
    localparam int ADV_PAUSE       = 10;
    localparam int ADV_RSV9        = 9;
    localparam int ADV_ABIL_HI     = 8;
    localparam int ADV_ABIL_LO     = 5;
    localparam logic [15:0] ADV_FIXED   = 16'h0801;
    localparam logic        ADV_PAUSE_RST = 1'b1;
    localparam logic [3:0]  ADV_ABIL_RST  = 4'hf;
    // Frame timing and opcodes
    localparam logic [5:0]  PREAMBLE_BITS = 6'h20;
    localparam logic [1:0]  OP_READ       = 2'b10;
    localparam logic [1:0]  OP_WRITE      = 2'b01;
endpackage
`default_nettype wire

// *** design/pmrf_top.sv ***
// Management register file for one transceiver port, reached over MDC/MDIO.
// Assumes MDC is at least 8x slower than clk_sys; status inputs are clk_sys logic.
`default_nettype none

// Functional notes
// - Writing one to control bit 9 pulses a negotiation restart; resets zero.
// - Control bit 8 selects full (1) or half (0) duplex; resets one.
// - Control bit 5 picks the crossover algorithm; read/write, resets one.
// - With crossover automation off, bit 4 forces straight (1) or crossed (0).
// - Control bit 3 set turns crossover automation off; resets zero.
// - Control bit 2 set disables far end fault detection; resets zero.
// - Control bit 1 set inhibits the transmitter; resets zero.
// - Control bit 0 set turns the indicator off; resets zero.
// - Status bits 14 to 11 read as fixed ability ones.
// - Status bit 15 always reads zero.
// - Status bit 0 always reads zero.
// - Status bit 5 shows negotiation completion; resets zero.
// - Status bit 4 shows far end fault seen; resets zero.
// - Status bit 3 reads constant one.
// - Status bit 2 shows live link state; resets zero.
// - Registers 2 and 3 return fixed identifier halves.
// - Advertisement bit 10 sets pause advertising; read/write, resets one.
// - Advertisement bits 8 to 5 select four abilities; each resets one.
// - Control bit 12 enables negotiation; restart and advert only act when enabled.
module pmrf_top #(
    parameter logic [4:0]  PORT_ADDR = 5'h01,
    parameter logic [15:0] IDENT_HI  = 16'h1234,   // Arbitrary identifier value
    parameter logic [15:0] IDENT_LO  = 16'h5678    // Arbitrary identifier value
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output var  logic       mdio_out,
    output var  logic       mdio_oe,
    input  wire logic       negotiation_done,
    input  wire logic       far_fault_seen,
    input  wire logic       link_up,
    output var  logic       negotiation_on,
    output var  logic       renegotiate_trigger,
    output var  logic       duplex_full,
    output var  logic       crossover_algo_sel,
    output var  logic       crossover_auto_off,
    output var  logic       wiring_mdi_forced,
    output var  logic       wiring_mdix_forced,
    output var  logic       far_fault_det_off,
    output var  logic       tx_inhibit,
    output var  logic       indicator_off,
    output var  logic       adv_pause_eff,
    output var  logic [3:0] adv_abil_eff
);

    typedef enum logic [2:0] {PH_PRE, PH_ST, PH_HDR, PH_TA, PH_DATA} pmrf_phase_t;

    typedef struct packed {
        logic        mdc_s1, mdc_s2, mdc_s3;
        logic        mdio_s1, mdio_s2;
        pmrf_phase_t phase;
        logic [5:0]  pre;
        logic [3:0]  cnt;
        logic [15:0] shift;
        logic        is_read;
        logic        hit;
        logic [4:0]  regad;
        logic        mdio_out, mdio_oe;
        logic        neg_on, reneg, duplex, algo, straight, auto_off;
        logic        fault_off, tx_off, ind_off;
        logic        adv_pause, adv_rsv9;
        logic [3:0]  adv_abil;
        logic        an_done, fault, link;
        logic        reneg_pulse;
        logic        adv_pause_eff;
        logic [3:0]  adv_abil_eff;
        logic        mdi_frc, mdix_frc;
    } pmrf_state_t;

    pmrf_state_t r, s;
    logic        rise;
    logic        bit_in;
    logic [11:0] hdr;
    logic [15:0] wdata;

    // Read-side decode; unmapped addresses return zero
    function automatic logic [15:0] read_word(input pmrf_state_t q, input logic [4:0] a);
        logic [15:0] w;
        w = 16'h0000;
        unique case (a)
            pmrf_pkg::REG_CTRL: begin
                w[pmrf_pkg::CTRL_NEG_ON]    = q.neg_on;
                w[pmrf_pkg::CTRL_RENEG]     = q.reneg;
                w[pmrf_pkg::CTRL_DUPLEX]    = q.duplex;
                w[pmrf_pkg::CTRL_ALGO]      = q.algo;
                w[pmrf_pkg::CTRL_STRAIGHT]  = q.straight;
                w[pmrf_pkg::CTRL_AUTO_OFF]  = q.auto_off;
                w[pmrf_pkg::CTRL_FAULT_OFF] = q.fault_off;
                w[pmrf_pkg::CTRL_TX_OFF]    = q.tx_off;
                w[pmrf_pkg::CTRL_IND_OFF]   = q.ind_off;
            end
            pmrf_pkg::REG_STATUS: begin
                w = pmrf_pkg::STAT_FIXED;
                w[pmrf_pkg::STAT_DONE]  = q.an_done;
                w[pmrf_pkg::STAT_FAULT] = q.fault;
                w[pmrf_pkg::STAT_LINK]  = q.link;
            end
            pmrf_pkg::REG_IDENT_HI: w = IDENT_HI;
            pmrf_pkg::REG_IDENT_LO: w = IDENT_LO;
            pmrf_pkg::REG_ADVERT: begin
                w = pmrf_pkg::ADV_FIXED;
                w[pmrf_pkg::ADV_PAUSE] = q.adv_pause;
                w[pmrf_pkg::ADV_RSV9]  = q.adv_rsv9;
                w[pmrf_pkg::ADV_ABIL_HI:pmrf_pkg::ADV_ABIL_LO] = q.adv_abil;
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // Edge of the synchronised clock and the data sampled beside it
    assign rise   = r.mdc_s2 & ~r.mdc_s3;
    assign bit_in = r.mdio_s2;
    assign hdr    = {r.shift[10:0], bit_in};
    assign wdata  = {r.shift[14:0], bit_in};

    // Next-state: frame decoder, register writes, status sampling
    always_comb begin
        s = r;
        s.mdc_s1      = mdc;
        s.mdc_s2      = r.mdc_s1;
        s.mdc_s3      = r.mdc_s2;
        s.mdio_s1     = mdio_in;
        s.mdio_s2     = r.mdio_s1;
        s.reneg_pulse = 1'b0;
        s.an_done     = negotiation_done;
        s.fault       = far_fault_seen;
        s.link        = link_up;
        if (rise) begin
            unique case (r.phase)
                PH_PRE: begin
                    // Preamble of ones, then the first start bit
                    if (bit_in) begin
                        if (r.pre < pmrf_pkg::PREAMBLE_BITS) s.pre = r.pre + 6'h01;
                    end else if (r.pre == pmrf_pkg::PREAMBLE_BITS) begin
                        s.phase = PH_ST;
                    end else begin
                        s.pre = 6'h00;
                    end
                end
                PH_ST: begin
                    s.pre   = 6'h00;
                    s.cnt   = 4'h0;
                    s.phase = bit_in ? PH_HDR : PH_PRE;
                end
                PH_HDR: begin
                    s.shift = wdata;
                    s.cnt   = r.cnt + 4'h1;
                    if (r.cnt == 4'hb) begin
                        // Only our own address with a legal opcode is served
                        s.is_read = (hdr[11:10] == pmrf_pkg::OP_READ);
                        s.hit     = (hdr[9:5] == PORT_ADDR) &&
                                    (hdr[11:10] == pmrf_pkg::OP_READ || hdr[11:10] == pmrf_pkg::OP_WRITE);
                        s.regad   = hdr[4:0];
                        s.cnt     = 4'h0;
                        s.phase   = PH_TA;
                    end
                end
                PH_TA: begin
                    s.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'h0) begin
                        // Host released the line; claim it with the zero bit
                        s.mdio_oe  = r.hit & r.is_read;
                        s.mdio_out = 1'b0;
                    end else begin
                        s.cnt      = 4'h0;
                        s.phase    = PH_DATA;
                        s.shift    = read_word(r, r.regad);
                        s.mdio_out = r.hit & r.is_read & s.shift[15];
                        s.shift    = {s.shift[14:0], 1'b0};
                    end
                end
                PH_DATA: begin
                    s.cnt = r.cnt + 4'h1;
                    if (r.is_read) begin
                        s.mdio_out = r.shift[15];
                        s.shift    = {r.shift[14:0], 1'b0};
                    end else begin
                        s.shift = wdata;
                    end
                    if (r.cnt == 4'hf) begin
                        s.mdio_oe  = 1'b0;
                        s.mdio_out = 1'b0;
                        s.phase    = PH_PRE;
                        s.pre      = 6'h00;
                        // Commit a write; read-only bits are never touched
                        if (r.hit && !r.is_read && r.regad == pmrf_pkg::REG_CTRL) begin
                            s.neg_on    = wdata[pmrf_pkg::CTRL_NEG_ON];
                            s.reneg     = wdata[pmrf_pkg::CTRL_RENEG];
                            s.reneg_pulse = wdata[pmrf_pkg::CTRL_RENEG] & r.neg_on;
                            s.duplex    = wdata[pmrf_pkg::CTRL_DUPLEX];
                            s.algo      = wdata[pmrf_pkg::CTRL_ALGO];
                            s.straight  = wdata[pmrf_pkg::CTRL_STRAIGHT];
                            s.auto_off  = wdata[pmrf_pkg::CTRL_AUTO_OFF];
                            s.fault_off = wdata[pmrf_pkg::CTRL_FAULT_OFF];
                            s.tx_off    = wdata[pmrf_pkg::CTRL_TX_OFF];
                            s.ind_off   = wdata[pmrf_pkg::CTRL_IND_OFF];
                        end
                        if (r.hit && !r.is_read && r.regad == pmrf_pkg::REG_ADVERT) begin
                            s.adv_pause = wdata[pmrf_pkg::ADV_PAUSE];
                            s.adv_rsv9  = wdata[pmrf_pkg::ADV_RSV9];
                            s.adv_abil  = wdata[pmrf_pkg::ADV_ABIL_HI:pmrf_pkg::ADV_ABIL_LO];
                        end
                    end
                end
                default: s.phase = PH_PRE;
            endcase
        end
        // Advertisement reaches the port only while negotiation is on
        s.adv_pause_eff = s.adv_pause & s.neg_on;
        s.adv_abil_eff  = s.adv_abil & {4{s.neg_on}};
        // Forced wiring decoded ahead of the flop so the pins carry no logic
        s.mdi_frc       = s.auto_off & s.straight;
        s.mdix_frc      = s.auto_off & ~s.straight;
    end

    // State register; reset gives constants only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r           <= '0;
            r.phase     <= PH_PRE;
            r.neg_on    <= pmrf_pkg::CTRL_NEG_ON_RST;
            r.duplex    <= pmrf_pkg::CTRL_DUPLEX_RST;
            r.algo      <= pmrf_pkg::CTRL_ALGO_RST;
            r.adv_pause <= pmrf_pkg::ADV_PAUSE_RST;
            r.adv_abil  <= pmrf_pkg::ADV_ABIL_RST;
            r.adv_pause_eff <= pmrf_pkg::ADV_PAUSE_RST & pmrf_pkg::CTRL_NEG_ON_RST;
            r.adv_abil_eff  <= pmrf_pkg::ADV_ABIL_RST & {4{pmrf_pkg::CTRL_NEG_ON_RST}};
        end else begin
            r <= s;
        end
    end

    // Ports straight from the state flops
    assign mdio_out            = r.mdio_out;
    assign mdio_oe             = r.mdio_oe;
    assign negotiation_on      = r.neg_on;
    assign renegotiate_trigger = r.reneg_pulse;
    assign duplex_full         = r.duplex;
    assign crossover_algo_sel  = r.algo;
    assign crossover_auto_off  = r.auto_off;
    assign wiring_mdi_forced   = r.mdi_frc;
    assign wiring_mdix_forced  = r.mdix_frc;
    assign far_fault_det_off   = r.fault_off;
    assign tx_inhibit          = r.tx_off;
    assign indicator_off       = r.ind_off;
    assign adv_pause_eff       = r.adv_pause_eff;
    assign adv_abil_eff        = r.adv_abil_eff;

    // Checks on the decoder and register contents
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    logic commit_ctrl;
    assign commit_ctrl = rise && r.phase == PH_DATA && r.cnt == 4'hf && r.hit && !r.is_read
                         && r.regad == pmrf_pkg::REG_CTRL;

    restart_gated_a: assert property (renegotiate_trigger |-> $past(commit_ctrl) && $past(r.neg_on))
        else $error("restart pulse without enabled write");
    duplex_hold_a: assert property (!$stable(duplex_full) |-> $past(commit_ctrl))
        else $error("duplex changed without a write");
    algo_hold_a: assert property (!$stable(crossover_algo_sel) |-> $past(commit_ctrl))
        else $error("crossover algorithm changed without a write");
    wiring_force_a: assert property ((wiring_mdi_forced | wiring_mdix_forced) == crossover_auto_off
                                     && !(wiring_mdi_forced && wiring_mdix_forced))
        else $error("forced wiring outputs inconsistent");
    tx_hold_a: assert property (!$stable({tx_inhibit, indicator_off, far_fault_det_off})
                                |-> $past(commit_ctrl))
        else $error("port disables changed without a write");
    status_const_a: assert property ((read_word(r, pmrf_pkg::REG_STATUS) & 16'hf809) == 16'h7808)
        else $error("status constant bits wrong");
    status_live_a: assert property (##1 r.link == $past(link_up) && r.an_done == $past(negotiation_done)
                                    && r.fault == $past(far_fault_seen))
        else $error("status bits do not follow inputs");
    ident_words_a: assert property (read_word(r, pmrf_pkg::REG_IDENT_HI) == IDENT_HI
                                    && read_word(r, pmrf_pkg::REG_IDENT_LO) == IDENT_LO)
        else $error("identifier words wrong");
    advert_const_a: assert property ((read_word(r, pmrf_pkg::REG_ADVERT) & 16'hf81f) == pmrf_pkg::ADV_FIXED)
        else $error("advertisement constant bits wrong");
    advert_gate_a: assert property (##1 adv_abil_eff == (r.adv_abil & {4{r.neg_on}}))
        else $error("effective advertisement not gated");
    turn_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out && r.phase == PH_TA)
        else $error("turnaround drive not zero");
    // Foreign or undefined frames must never claim the shared data line
    drive_own_a: assert property (mdio_oe |-> r.hit && r.is_read)
        else $error("data line driven outside own read");

    read_frame_c: cover property ($rose(mdio_oe) ##[1:1000] $fell(mdio_oe));
    ctrl_write_c: cover property (commit_ctrl);
    restart_c:    cover property (renegotiate_trigger);
    foreign_c:    cover property (rise && r.phase == PH_DATA && r.cnt == 4'hf && !r.hit);

endmodule // pmrf_top
`default_nettype wire

// *** verification/pmrf_host_model.sv ***
// Behavioural management host: whole frames on mdc/mdio, read words out.
// Assumes the bench resolves the mdio line with a pull-up and feeds it back.
`default_nettype none
module pmrf_host_model #(
    parameter int HALF_MDC = 6
) (
    input  wire logic        clk_sys,
    input  wire logic        mdio_line,
    output var  logic        mdc,
    output var  logic        host_out,
    output var  logic        host_oe,
    output var  logic        rd_valid,
    output var  logic [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: mdc stands low, mdio released
    initial begin
        mdc = 1'b0;
        host_out = 1'b1;
        host_oe = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end

    // Fresh preamble every frame; for every opcode but write, host lets go of mdio for turnaround and data
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                         input logic [15:0] wdata);
        logic [63:0] bits;
        logic [15:0] got;
        bits = {32'hffff_ffff, 2'b01, op, phy, reg_a, 2'b10, wdata};
        got = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            host_oe = (op == pmrf_pkg::OP_WRITE) || (i < 46);
            host_out = bits[63 - i];
            repeat (HALF_MDC) @(posedge clk_sys);
            #1 mdc = 1'b1;
            if (i >= 48) got = {got[14:0], mdio_line};
            repeat (HALF_MDC) @(posedge clk_sys);
            #1 mdc = 1'b0;
        end
        host_oe = 1'b0;
        if (op == pmrf_pkg::OP_READ) begin
            rd_data = got;
            rd_valid = 1'b1;
            @(posedge clk_sys);
            #1 rd_valid = 1'b0;
        end
    endtask
endmodule // pmrf_host_model
`default_nettype wire

// *** verification/pmrf_top_tb.sv ***
// Self-checking bench for the port management register file.
// Assumes pmrf_pkg and pmrf_host_model compiled first; mdio has a pull-up.
`default_nettype none
module pmrf_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0]  PA    = 5'h03;
    localparam logic [4:0]  OTHER = 5'h01;
    localparam logic [15:0] ID_HI = 16'h3c5a; // Arbitrary identifier value
    localparam logic [15:0] ID_LO = 16'ha5c3; // Arbitrary identifier value
    localparam int          LIMIT = 60000;
    logic        clk_sys, arst_n, mdc, host_out, host_oe, rd_valid, mdio_line, mdio_out, mdio_oe;
    logic        negotiation_done, far_fault_seen, link_up, negotiation_on, renegotiate_trigger;
    logic        duplex_full, crossover_algo_sel, crossover_auto_off, wiring_mdi_forced;
    logic        wiring_mdix_forced, far_fault_det_off, tx_inhibit, indicator_off, adv_pause_eff;
    logic [3:0]  adv_abil_eff;
    logic [15:0] rd_data, ctrl_m, adv_m, w;
    logic [31:0] lfsr;
    logic [15:0] exp_q[$];
    logic [15:0] ctl_tab[6] = '{16'hffff, 16'h0000, 16'h1200, 16'h1200, 16'h1018, 16'h1008};
    int          mismatches, total_checks, trig_cnt, trig_exp, cycles;

    // Pull-up wins when nobody drives
    assign mdio_line = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);

    pmrf_top #(.PORT_ADDR(PA), .IDENT_HI(ID_HI), .IDENT_LO(ID_LO)) pmrf_top_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .negotiation_done(negotiation_done), .far_fault_seen(far_fault_seen),
        .link_up(link_up), .negotiation_on(negotiation_on), .renegotiate_trigger(renegotiate_trigger),
        .duplex_full(duplex_full), .crossover_algo_sel(crossover_algo_sel),
        .crossover_auto_off(crossover_auto_off), .wiring_mdi_forced(wiring_mdi_forced),
        .wiring_mdix_forced(wiring_mdix_forced), .far_fault_det_off(far_fault_det_off),
        .tx_inhibit(tx_inhibit), .indicator_off(indicator_off), .adv_pause_eff(adv_pause_eff),
        .adv_abil_eff(adv_abil_eff));

    pmrf_host_model #(.HALF_MDC(6)) pmrf_host_model_i (
        .clk_sys(clk_sys), .mdio_line(mdio_line), .mdc(mdc), .host_out(host_out),
        .host_oe(host_oe), .rd_valid(rd_valid), .rd_data(rd_data));

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Read notes its expectation; the watcher below compares when the word arrives
    task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
        exp_q.push_back(exp);
        pmrf_host_model_i.frame(pmrf_pkg::OP_READ, phy, ra, 16'h0000);
    endtask

    // Write, then let the register effect land
    task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
        pmrf_host_model_i.frame(pmrf_pkg::OP_WRITE, phy, ra, d);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    // Control and advert side outputs against the modelled register contents
    task automatic chk_outs;
        check("ctrl outputs", {7'h00, negotiation_on, duplex_full, crossover_algo_sel, crossover_auto_off,
              wiring_mdi_forced, wiring_mdix_forced, far_fault_det_off, tx_inhibit, indicator_off},
              {7'h00, ctrl_m[12], ctrl_m[8], ctrl_m[5], ctrl_m[3], ctrl_m[3] & ctrl_m[4],
               ctrl_m[3] & ~ctrl_m[4], ctrl_m[2], ctrl_m[1], ctrl_m[0]});
        check("advert outputs", {11'h000, adv_pause_eff, adv_abil_eff},
              {11'h000, adv_m[10] & ctrl_m[12], adv_m[8:5] & {4{ctrl_m[12]}}});
        check("trigger pulses", trig_cnt[15:0], trig_exp[15:0]);
    endtask

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Watcher: oldest note against each arriving read word
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", 16'(exp_q.size()), 16'h0001);
            else check("read word", rd_data, exp_q.pop_front());
        end
    end

    // Pulse counter and hang guard
    always @(posedge clk_sys) begin
        if (renegotiate_trigger === 1'b1) trig_cnt++;
        cycles++;
        if (cycles >= LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        negotiation_done = 1'b0;
        far_fault_seen = 1'b0;
        link_up = 1'b0;
        lfsr = 32'h2946_104f;
        ctrl_m = 16'h1120;
        adv_m = 16'h0de1;
        repeat (6) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk_outs();
        rd(PA, pmrf_pkg::REG_CTRL, 16'h1120);
        rd(PA, pmrf_pkg::REG_ADVERT, 16'h0de1);
        wr(PA, pmrf_pkg::REG_IDENT_HI, ~ID_HI);
        rd(PA, pmrf_pkg::REG_IDENT_HI, ID_HI);
        rd(PA, pmrf_pkg::REG_IDENT_LO, ID_LO);
        rd(PA, 5'h05, 16'h0000);
        // Status under random live inputs, after a write it must ignore
        for (int k = 0; k < 6; k++) begin
            lfsr = lfsr_next(lfsr);
            negotiation_done = lfsr[0];
            far_fault_seen = lfsr[1];
            link_up = lfsr[2];
            wr(PA, pmrf_pkg::REG_STATUS, lfsr[31:16]);
            rd(PA, pmrf_pkg::REG_STATUS, 16'h7808 | {10'h000, lfsr[0], lfsr[1], 1'b0, lfsr[2], 2'b00});
        end
        // Control writes: fixed corner values, then random; each followed by a random advert write
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            w = (k < 6) ? ctl_tab[k] : lfsr[15:0];
            if (w[9] && ctrl_m[12]) trig_exp++;
            ctrl_m = w & 16'h133f;
            wr(PA, pmrf_pkg::REG_CTRL, w);
            chk_outs();
            rd(PA, pmrf_pkg::REG_CTRL, ctrl_m);
            lfsr = lfsr_next(lfsr);
            adv_m = 16'h0801 | (lfsr[15:0] & 16'h07e0);
            wr(PA, pmrf_pkg::REG_ADVERT, lfsr[15:0]);
            chk_outs();
            rd(PA, pmrf_pkg::REG_ADVERT, adv_m);
        end
        // Undefined opcodes are passive even at our own address
        pmrf_host_model_i.frame(2'b11, PA, pmrf_pkg::REG_CTRL, ~ctrl_m);
        pmrf_host_model_i.frame(2'b00, PA, pmrf_pkg::REG_ADVERT, ~adv_m);
        repeat (8) @(posedge clk_sys);
        #1;
        chk_outs();
        rd(PA, pmrf_pkg::REG_CTRL, ctrl_m);
        // Frames for another port leave this one untouched and undriven
        wr(OTHER, pmrf_pkg::REG_CTRL, ~ctrl_m);
        chk_outs();
        rd(OTHER, pmrf_pkg::REG_CTRL, 16'hffff);
        repeat (4) @(posedge clk_sys);
        check("pending reads", 16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
endmodule // pmrf_top_tb
`default_nettype wire
